// File: inc/frt_defines.svh
`ifndef FRT_DEFINES_SVH
`define FRT_DEFINES_SVH

// direct register addresses on the register port
`define FRT_ADDR_CTRL        8'h6E
`define FRT_ADDR_OFFSET      8'h6F
`define FRT_ADDR_DATA        8'hA0

// control byte fields
`define FRT_TSEL_MSB         7
`define FRT_TSEL_LSB         5
`define FRT_TSEL_FILTER      3'h2
`define FRT_PORT_MSB         3
`define FRT_PORT_LSB         0
`define FRT_PORT_FIRST       4'h1
`define FRT_PORT_LAST        4'h5

// entry byte offsets
`define FRT_OFF_FIRST        8'h02
`define FRT_OFF_LAST         8'h09
`define FRT_OFF_IP_B3        8'h02
`define FRT_OFF_IP_B2        8'h03
`define FRT_OFF_IP_B1        8'h04
`define FRT_OFF_IP_B0        8'h05
`define FRT_OFF_MASK_B3      8'h06
`define FRT_OFF_MASK_B2      8'h07
`define FRT_OFF_MASK_B1      8'h08
`define FRT_OFF_MASK_B0      8'h09
`define FRT_OFF_RMAX_HI      8'h02
`define FRT_OFF_RMIN_LO      8'h03

// storage geometry
`define FRT_NUM_PORTS        5
`define FRT_SLOTS            8
`define FRT_DEPTH            40
`define FRT_IDX_W            6

// reset values
`define FRT_BYTE_RESET       8'h00
`define FRT_IDX_RESET        6'h00

`endif

// File: inc/frt_pkg.sv
package frt_pkg;

	// one byte of register data
	typedef logic [7:0] frt_byte_t;

	// entry storage index
	typedef logic [5:0] frt_idx_t;

	// source of a pending read answer, one-hot
	typedef enum logic [3:0] {
		FRT_SRC_NONE   = 4'h1,
		FRT_SRC_CTRL   = 4'h2,
		FRT_SRC_OFFSET = 4'h4,
		FRT_SRC_DATA   = 4'h8
	} frt_src_e;

endpackage : frt_pkg

// File: verilog/frt_entry_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "frt_defines.svh"

module frt_entry_mem (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// write side
	input  wire logic                       wr_en,
	input  wire frt_pkg::frt_idx_t          wr_idx,
	input  wire frt_pkg::frt_byte_t         wr_data,
	// read side, data one cycle after the index
	input  wire frt_pkg::frt_idx_t          rd_idx,
	output frt_pkg::frt_byte_t              rd_data_ff,
	// whole contents for the match logic
	output logic [`FRT_DEPTH*8-1:0]         image
);

	// byte storage, every port and slot
	frt_pkg::frt_byte_t storage_ff [0:`FRT_DEPTH-1];

	// storage update, all bytes clear on reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `FRT_DEPTH; i++) begin
				storage_ff[i] <= `FRT_BYTE_RESET;
			end
		end else if (wr_en) begin
			storage_ff[wr_idx] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= `FRT_BYTE_RESET;
		end else begin
			rd_data_ff <= storage_ff[rd_idx];
		end
	end

	// flatten storage for the match fields
	always_comb begin
		image = '0;
		for (int i = 0; i < `FRT_DEPTH; i++) begin
			image[i*8 +: 8] = storage_ff[i];
		end
	end

endmodule : frt_entry_mem
`default_nettype wire

// File: verilog/frt_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "frt_defines.svh"

module frt_regs (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// register port: write request
	input  wire logic                       reg_wr,
	input  wire logic [7:0]                 reg_addr,
	input  wire frt_pkg::frt_byte_t         reg_wdata,
	// register port: read request and answer
	input  wire logic                       reg_rd,
	output frt_pkg::frt_byte_t              reg_rdata_ff,
	output logic                            reg_rvalid_ff,
	// indirect access status
	output logic                            entry_sel_ok,
	// layer-3 match fields, port n at bits (n-1)*32
	output logic [`FRT_NUM_PORTS*32-1:0]    match_ip_value,
	output logic [`FRT_NUM_PORTS*32-1:0]    match_ip_bitmask,
	// layer-4 range bytes, port n at bits (n-1)*8
	output logic [`FRT_NUM_PORTS*8-1:0]     range_max_high,
	output logic [`FRT_NUM_PORTS*8-1:0]     range_min_low
);

	// is the control byte pointing at the filter table and a real port
	function automatic logic sel_valid(input frt_pkg::frt_byte_t ctrl);
		logic [3:0] port;
		port = ctrl[`FRT_PORT_MSB:`FRT_PORT_LSB];
		sel_valid = (ctrl[`FRT_TSEL_MSB:`FRT_TSEL_LSB] == `FRT_TSEL_FILTER)
			&& (port >= `FRT_PORT_FIRST) && (port <= `FRT_PORT_LAST);
	endfunction : sel_valid

	// does the offset land on a stored entry byte
	function automatic logic off_valid(input frt_pkg::frt_byte_t off);
		off_valid = (off >= `FRT_OFF_FIRST) && (off <= `FRT_OFF_LAST);
	endfunction : off_valid

	// storage index from port and offset: eight slots per port
	function automatic frt_pkg::frt_idx_t entry_index(input frt_pkg::frt_byte_t ctrl,
		input frt_pkg::frt_byte_t off);
		logic [3:0] port_rel;
		logic [7:0] off_rel;
		port_rel = ctrl[`FRT_PORT_MSB:`FRT_PORT_LSB] - `FRT_PORT_FIRST;
		off_rel  = off - `FRT_OFF_FIRST;
		entry_index = {port_rel[2:0], off_rel[2:0]};
	endfunction : entry_index

	// storage slot of an offset within one port
	function automatic int slot_of(input frt_pkg::frt_byte_t off);
		frt_pkg::frt_byte_t rel;
		rel = off - `FRT_OFF_FIRST;
		slot_of = int'(rel[2:0]);
	endfunction : slot_of

	// control byte: table select and port select
	frt_pkg::frt_byte_t ctrl_ff;
	// offset byte: which entry byte the data register reaches
	frt_pkg::frt_byte_t offset_ff;
	// pending read source
	frt_pkg::frt_src_e  src_ff;
	frt_pkg::frt_src_e  nxt_src;
	// first stage of a pending read
	logic               rd_stage_ff;

	// decoded accesses
	logic               hit;
	logic               data_wr;
	frt_pkg::frt_idx_t  acc_idx;
	// memory read byte
	frt_pkg::frt_byte_t mem_rdata;
	// flattened storage
	logic [`FRT_DEPTH*8-1:0] image;

	// indirect selection decode
	always_comb begin
		hit     = sel_valid(ctrl_ff) && off_valid(offset_ff);
		acc_idx = hit ? entry_index(ctrl_ff, offset_ff) : `FRT_IDX_RESET;
		data_wr = reg_wr && (reg_addr == `FRT_ADDR_DATA) && hit;
	end

	assign entry_sel_ok = hit;

	// control byte register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= `FRT_BYTE_RESET;
		end else if (reg_wr && (reg_addr == `FRT_ADDR_CTRL)) begin
			ctrl_ff <= reg_wdata;
		end
	end

	// offset byte register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_ff <= `FRT_BYTE_RESET;
		end else if (reg_wr && (reg_addr == `FRT_ADDR_OFFSET)) begin
			offset_ff <= reg_wdata;
		end
	end

	// entry byte storage, one shared memory with eight slots per port
	frt_entry_mem u_mem (
		.clk        (clk),
		.rst_n      (rst_n),
		.wr_en      (data_wr),
		.wr_idx     (acc_idx),
		.wr_data    (reg_wdata),
		.rd_idx     (acc_idx),
		.rd_data_ff (mem_rdata),
		.image      (image)
	);

	// read request decode into a one-hot source
	always_comb begin
		if (!reg_rd) begin
			nxt_src = frt_pkg::FRT_SRC_NONE;
		end else begin
			case (reg_addr)
				`FRT_ADDR_CTRL: begin
					nxt_src = frt_pkg::FRT_SRC_CTRL;
				end
				`FRT_ADDR_OFFSET: begin
					nxt_src = frt_pkg::FRT_SRC_OFFSET;
				end
				`FRT_ADDR_DATA: begin
					// unselected bytes answer zero
					nxt_src = hit ? frt_pkg::FRT_SRC_DATA : frt_pkg::FRT_SRC_NONE;
				end
				default: begin
					// unmapped address answers zero
					nxt_src = frt_pkg::FRT_SRC_NONE;
				end
			endcase
		end
	end

	// first read stage: remember source while memory fetches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_ff      <= frt_pkg::FRT_SRC_NONE;
			rd_stage_ff <= 1'b0;
		end else begin
			src_ff      <= nxt_src;
			rd_stage_ff <= reg_rd;
		end
	end

	// second read stage: answer byte and valid pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_ff  <= `FRT_BYTE_RESET;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= rd_stage_ff;
			if (rd_stage_ff) begin
				case (src_ff)
					frt_pkg::FRT_SRC_CTRL: begin
						reg_rdata_ff <= ctrl_ff;
					end
					frt_pkg::FRT_SRC_OFFSET: begin
						reg_rdata_ff <= offset_ff;
					end
					frt_pkg::FRT_SRC_DATA: begin
						reg_rdata_ff <= mem_rdata;
					end
					frt_pkg::FRT_SRC_NONE: begin
						reg_rdata_ff <= `FRT_BYTE_RESET;
					end
					default: begin
						reg_rdata_ff <= `FRT_BYTE_RESET;
					end
				endcase
			end
		end
	end

	// match fields per port, assembled msb first from stored slots
	always_comb begin
		int base;
		base             = 0;
		match_ip_value   = '0;
		match_ip_bitmask = '0;
		range_max_high   = '0;
		range_min_low    = '0;
		for (int p = 0; p < `FRT_NUM_PORTS; p++) begin
			base = p * `FRT_SLOTS;
			// ip value bytes 31:24 down to 7:0
			match_ip_value[p*32+24 +: 8]   = image[(base + slot_of(`FRT_OFF_IP_B3))*8 +: 8];
			match_ip_value[p*32+16 +: 8]   = image[(base + slot_of(`FRT_OFF_IP_B2))*8 +: 8];
			match_ip_value[p*32+8 +: 8]    = image[(base + slot_of(`FRT_OFF_IP_B1))*8 +: 8];
			match_ip_value[p*32 +: 8]      = image[(base + slot_of(`FRT_OFF_IP_B0))*8 +: 8];
			// match_ip_bitmask bytes 31:24 down to 7:0
			match_ip_bitmask[p*32+24 +: 8] = image[(base + slot_of(`FRT_OFF_MASK_B3))*8 +: 8];
			match_ip_bitmask[p*32+16 +: 8] = image[(base + slot_of(`FRT_OFF_MASK_B2))*8 +: 8];
			match_ip_bitmask[p*32+8 +: 8]  = image[(base + slot_of(`FRT_OFF_MASK_B1))*8 +: 8];
			match_ip_bitmask[p*32 +: 8]    = image[(base + slot_of(`FRT_OFF_MASK_B0))*8 +: 8];
			// layer-4 view of the same entry bytes
			range_max_high[p*8 +: 8]       = image[(base + slot_of(`FRT_OFF_RMAX_HI))*8 +: 8];
			range_min_low[p*8 +: 8]        = image[(base + slot_of(`FRT_OFF_RMIN_LO))*8 +: 8];
		end
	end

endmodule : frt_regs
`default_nettype wire

// File: bench/frt_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module frt_regs_chk (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// register port
	input wire logic               reg_wr,
	input wire logic [7:0]         reg_addr,
	input wire frt_pkg::frt_byte_t reg_wdata,
	input wire logic               reg_rd,
	input wire frt_pkg::frt_byte_t reg_rdata_ff,
	input wire logic               reg_rvalid_ff,
	input wire logic               entry_sel_ok,
	// match views
	input wire logic [159:0]       match_ip_value,
	input wire logic [159:0]       match_ip_bitmask,
	input wire logic [39:0]        range_max_high,
	input wire logic [39:0]        range_min_low
);
	logic [7:0] ctrl_ff;  // control byte as last written
	logic [7:0] off_ff;   // offset byte as last written
	logic [7:0] cur_byte; // entry byte the selection points at
	logic       sel_ok;   // expected selection validity
	logic       alias_ok; // layer-4 bytes equal the shared ip bytes
	int         pi;       // selected port index
	int         bi;       // selected byte index
	// mirror control and offset writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= 8'h00;
			off_ff <= 8'h00;
		end else if (reg_wr && reg_addr == 8'h6E) begin
			ctrl_ff <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h6F) begin
			off_ff <= reg_wdata;
		end
	end
	// expected selection and the byte it reaches
	always_comb begin
		sel_ok = ctrl_ff[7:5] == 3'h2 && ctrl_ff[3:0] >= 4'h1 && ctrl_ff[3:0] <= 4'h5;
		sel_ok = sel_ok && off_ff >= 8'h02 && off_ff <= 8'h09;
		pi = int'(ctrl_ff[3:0]) - 1;
		bi = int'(off_ff) - 2;
		cur_byte = 8'h00;
		if (sel_ok) begin
			cur_byte = bi < 4 ? match_ip_value[pi*32+(3-bi)*8+:8] : match_ip_bitmask[pi*32+(7-bi)*8+:8];
		end
		alias_ok = 1'b1;
		for (int i = 0; i < 5; i++) begin
			alias_ok = alias_ok && range_max_high[i*8+:8] == match_ip_value[i*32+24+:8];
			alias_ok = alias_ok && range_min_low[i*8+:8] == match_ip_value[i*32+16+:8];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_read_latency: assert property (reg_rd |-> ##2 reg_rvalid_ff)
		else $error("read answer late");
	chk_valid_cause: assert property (reg_rvalid_ff |-> $past(reg_rd, 2))
		else $error("read answer without request");
	chk_ctrl_readback: assert property (reg_rd && reg_addr == 8'h6E |-> ##2 reg_rdata_ff == $past(ctrl_ff, 2))
		else $error("control readback wrong");
	chk_off_readback: assert property (reg_rd && reg_addr == 8'h6F |-> ##2 reg_rdata_ff == $past(off_ff, 2))
		else $error("offset readback wrong");
	chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h6E, 8'h6F, 8'hA0}) |-> ##2 reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	chk_sel_flag: assert property (entry_sel_ok == sel_ok)
		else $error("selection flag wrong");
	chk_data_read: assert property (reg_rd && reg_addr == 8'hA0 |-> ##2 reg_rdata_ff == $past(cur_byte, 2))
		else $error("indirect read wrong");
	chk_data_write: assert property (reg_wr && reg_addr == 8'hA0 && sel_ok |=> cur_byte == $past(reg_wdata))
		else $error("indirect write lost");
	chk_refused_write: assert property (reg_wr && reg_addr == 8'hA0 && !sel_ok |=>
		$stable(match_ip_value) && $stable(match_ip_bitmask)) else $error("refused write stored");
	chk_layer4_alias: assert property (alias_ok)
		else $error("range view mismatch");
	cover property (reg_wr && reg_addr == 8'hA0 && sel_ok);
	cover property (reg_wr && reg_addr == 8'hA0 && !sel_ok);
	cover property (reg_rd && reg_addr == 8'hA0 && sel_ok);
endmodule : frt_regs_chk
bind frt_regs frt_regs_chk frt_regs_chk_inst (.clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rd, .reg_rdata_ff,
	.reg_rvalid_ff, .entry_sel_ok, .match_ip_value, .match_ip_bitmask, .range_max_high, .range_min_low);
`default_nettype wire

// File: bench/frt_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module frt_regs_tb;
	// design connections
	logic         clk;
	logic         rst_n;
	logic         reg_wr;
	logic         reg_rd;
	logic [7:0]   reg_addr;
	logic [7:0]   reg_wdata;
	logic [7:0]   rdata;
	logic         rvalid;
	logic         sel_ok;
	logic [159:0] ipv;
	logic [159:0] ipm;
	logic [39:0]  rmax;
	logic [39:0]  rmin;
	logic [7:0]   mdl [1:5][2:9]; // expected bytes, port by offset
	logic [7:0]   got;            // last read answer
	int           n_errors;
	int           total_checks;
	frt_regs frt_regs_inst (.clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rd, .reg_rdata_ff(rdata),
		.reg_rvalid_ff(rvalid), .entry_sel_ok(sel_ok), .match_ip_value(ipv), .match_ip_bitmask(ipm),
		.range_max_high(rmax), .range_min_low(rmin));
	// clock
	always #25 clk = ~clk;
	// byte compare
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] act);
		total_checks++;
		if (act !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, act);
		end
	endtask : cmp
	// verdict
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// one write at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	// one read, bounded wait for the answer
	task automatic rd(input logic [7:0] a);
		int k;
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
			@(negedge clk);
		end
		if (k == 4) begin
			n_errors++;
			conclude();
		end
		got = rdata;
	endtask : rd
	// select table, port and offset
	task automatic sel(input logic [3:0] p, input logic [7:0] o);
		wr(8'h6E, {3'h2, 1'b0, p});
		wr(8'h6F, o);
	endtask : sel
	// compare all ports' views with the expected bytes
	task automatic views;
		for (int p = 1; p <= 5; p++) begin
			for (int o = 2; o <= 9; o++) begin
				cmp("view", mdl[p][o], o < 6 ? ipv[(p-1)*32+(5-o)*8+:8] : ipm[(p-1)*32+(9-o)*8+:8]);
			end
			cmp("max", mdl[p][2], rmax[(p-1)*8+:8]);
			cmp("min", mdl[p][3], rmin[(p-1)*8+:8]);
		end
	endtask : views
	// reset pulse, expected bytes cleared
	task automatic do_reset(input int n);
		rst_n = 1'b0;
		repeat (n) @(negedge clk);
		rst_n = 1'b1;
		foreach (mdl[p, o]) begin
			mdl[p][o] = 8'h00;
		end
	endtask : do_reset
	// main sequence
	initial begin
		logic [3:0] p;
		logic [7:0] o;
		logic [7:0] d;
		clk = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		n_errors = 0;
		total_checks = 0;
		void'($urandom(32'h0832D519));
		do_reset(16);
		views();
		rd(8'h6E);
		cmp("control", 8'h00, got);
		// random entry writes, each read back
		for (int i = 0; i < 80; i++) begin
			p = 4'(1 + $urandom % 5);
			o = 8'(2 + $urandom % 8);
			d = i == 0 ? 8'hFF : 8'($urandom);
			sel(p, o);
			cmp("flag", 8'h01, {7'h00, sel_ok});
			wr(8'hA0, d);
			mdl[p][o] = d;
			rd(8'hA0);
			cmp("entry", d, got);
		end
		views();
		// wrong table, port 0, port 6, offsets 01 and 0A
		for (int i = 0; i < 5; i++) begin
			sel(i == 1 ? 4'h0 : i == 2 ? 4'h6 : 4'h3, i == 3 ? 8'h01 : i == 4 ? 8'h0A : 8'h05);
			if (i == 0) wr(8'h6E, 8'h63);
			cmp("flag", 8'h00, {7'h00, sel_ok});
			wr(8'hA0, 8'hC3);
			rd(8'hA0);
			cmp("refused", 8'h00, got);
		end
		views();
		wr(8'h70, 8'h5A);
		rd(8'h70);
		cmp("unmapped", 8'h00, got);
		d = 8'($urandom);
		wr(8'h6F, d);
		rd(8'h6F);
		cmp("offset", d, got);
		do_reset(2);
		views();
		conclude();
	end
endmodule : frt_regs_tb
`default_nettype wire
